// ===== common/isc_pkg.sv
// Shared constants and types for the I2C clock generator and interrupt block
package isc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets (AHB-Lite, one aligned word each)
  localparam logic [7:0] OFF_CTRL = 8'h00;   // Control: run, master, filter, DMA
  localparam logic [7:0] OFF_HIGH = 8'h04;   // High period setting
  localparam logic [7:0] OFF_LOW = 8'h08;    // Low period setting
  localparam logic [7:0] OFF_STAT = 8'h0c;   // Sticky event status, read only
  localparam logic [7:0] OFF_IEN = 8'h10;    // Interrupt enable
  localparam logic [7:0] OFF_ICLR = 8'h14;   // Status clear, write only
  localparam logic [7:0] OFF_STATE = 8'h18;  // Live state, read only

  ////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CTRL_RUN = 0;     // Module released from stop
  localparam int CTRL_MST = 1;     // Master clock generation on
  localparam int CTRL_NFE = 2;     // Noise filter enabled
  localparam int CTRL_NFW = 3;     // Noise width select, 2 bits
  localparam int CTRL_DRX = 5;     // DMA on receive full
  localparam int CTRL_DTX = 6;     // DMA on transmit empty
  localparam int CTRL_W = 7;       // Control register width

  // Status field positions
  localparam int ST_AL = 0;        // Arbitration lost
  localparam int ST_NACK = 1;      // NACK detected
  localparam int ST_TMO = 2;       // Timeout
  localparam int ST_STA = 3;       // Start condition
  localparam int ST_STP = 4;       // Stop condition
  localparam int ST_RXF = 5;       // Receive data full
  localparam int ST_TXE = 6;       // Transmit data empty
  localparam int ST_TEND = 7;      // Transmit end
  localparam int ST_W = 8;         // Status width
  localparam logic [ST_W-1:0] ST_ERR_MASK = 8'h1f;  // Error/event group

  // Pending request indices, highest priority first
  localparam int PND_ERR = 0;
  localparam int PND_RXI = 1;
  localparam int PND_TXI = 2;
  localparam int PND_TEI = 3;
  localparam int PND_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [7:0] HIGH_RST = 8'h10;
  localparam logic [7:0] LOW_RST = 8'h10;
  localparam logic [ST_W-1:0] IEN_RST = 8'h00;

  // Filter depth in latch stages
  localparam int NF_STAGES = 4;

  // Clock generator states, Gray along IDLE-LOW-REL-HIGH
  typedef enum logic [1:0] {
    ISC_IDLE = 2'b00,
    ISC_LOW = 2'b01,
    ISC_REL = 2'b11,
    ISC_HIGH = 2'b10
  } isc_state_t;

endpackage

// ===== rtl/isc_noise_filter.sv
// Digital noise filter for one bus input
`timescale 1ns/10ps
`default_nettype none
module isc_noise_filter #(
  parameter int STAGES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic din,
  input wire logic en,
  input wire logic [1:0] width,
  output logic dout
);

  ////////////////////////////////////////////////////////////////////////////
  // Sample history and window mask
  logic [STAGES-1:0] sh_q;     // Newest sample in bit 0
  logic [STAGES-1:0] mask;     // Samples that must agree
  logic dout_q;                // Filtered level
  wire agree_hi = &(sh_q | ~mask);
  wire agree_lo = ~|(sh_q & mask);

  // Window is width+1 samples wide
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_mask
      assign mask[i] = (i <= int'(width));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Shift samples; output moves only on a unanimous window, or follows when bypassed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_q <= '1;
      dout_q <= 1'b1;
    end else begin
      sh_q <= {sh_q[STAGES-2:0], din};
      dout_q <= !en ? din : agree_hi ? 1'b1 : agree_lo ? 1'b0 : dout_q;
    end
  end

  assign dout = dout_q;

endmodule
`default_nettype wire

// ===== rtl/isc_top.sv
// I2C clock generation, clock synchronisation and interrupt block with AHB-Lite registers
// How it works
// - Transfers are timed by the master's clock.
// - High and low counts set rate, duty.
// - High count match clears, drives line low.
// - Low count match clears, releases line.
// - High count starts at sensed rising edge.
// - Low count starts at any falling edge.
// - Master watches line, syncs each bit.
// - Transfer conditions hold clock low automatically.
// - Switchable noise filter with width select.
// - Only receive-full, transmit-empty request DMA.
// - Receive/transmit request during pending flag is stored, replayed.
// - Pending flag clears on controller accept.
// - Group flag clears with module status.
// - Stopped after reset until released.
`timescale 1ns/10ps
`default_nettype none
module isc_top #(
  parameter int CNT_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_filt,
  input wire logic hold_tx,
  input wire logic hold_nack,
  input wire logic hold_rx,
  input wire logic [isc_pkg::ST_W-1:0] evt,
  input wire logic [isc_pkg::PND_W-1:0] intc_ack,
  output logic [isc_pkg::PND_W-1:0] pend_flag,
  output logic grp_flag,
  output logic [1:0] prio_src,
  output logic prio_valid,
  output logic [1:0] dma_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [isc_pkg::CTRL_W-1:0] ctrl_q;         // Control bits
  logic [CNT_W-1:0] high_q;                   // High period setting
  logic [CNT_W-1:0] low_q;                    // Low period setting
  logic [isc_pkg::ST_W-1:0] stat_q;           // Sticky status
  logic [isc_pkg::ST_W-1:0] stat_d;
  logic [isc_pkg::ST_W-1:0] ien_q;            // Interrupt enable
  logic [31:0] hrdata_q;                      // Registered read data
  logic [7:0] waddr_q;                        // Write data-phase address
  logic wr_q;                                 // Write data phase pending

  // Pending requests and stored requests
  logic [isc_pkg::PND_W-1:0] pend_q;
  logic [isc_pkg::PND_W-1:0] pend_d;
  logic [isc_pkg::PND_W-1:0] store_q;
  logic [isc_pkg::PND_W-1:0] store_d;
  logic [isc_pkg::PND_W-1:0] req_evt;         // One-cycle request per source

  // Clock generator
  isc_pkg::isc_state_t st_q;
  isc_pkg::isc_state_t st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic scl_f;                                // Filtered clock line
  logic scl_f_q;                              // Previous filtered level

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire addr_ph = hsel && htrans[1] && hready;
  wire [7:0] aaddr = haddr[7:0];
  wire wr_ctrl = wr_q && (waddr_q == isc_pkg::OFF_CTRL);
  wire wr_high = wr_q && (waddr_q == isc_pkg::OFF_HIGH);
  wire wr_low = wr_q && (waddr_q == isc_pkg::OFF_LOW);
  wire wr_ien = wr_q && (waddr_q == isc_pkg::OFF_IEN);
  wire wr_iclr = wr_q && (waddr_q == isc_pkg::OFF_ICLR);

  // Read mux; unmapped and write-only offsets read zero
  logic [31:0] rd_mux;
  wire [31:0] state_word = {22'h0, pend_q, store_q[isc_pkg::PND_TXI:isc_pkg::PND_RXI], sda_filt, scl_f, st_q};
  assign rd_mux = (aaddr == isc_pkg::OFF_CTRL) ? 32'(ctrl_q) :
                  (aaddr == isc_pkg::OFF_HIGH) ? 32'(high_q) :
                  (aaddr == isc_pkg::OFF_LOW) ? 32'(low_q) :
                  (aaddr == isc_pkg::OFF_STAT) ? 32'(stat_q) :
                  (aaddr == isc_pkg::OFF_IEN) ? 32'(ien_q) :
                  (aaddr == isc_pkg::OFF_STATE) ? state_word : 32'h0000_0000;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Capture address phase; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_ph && hwrite;
      waddr_q <= aaddr;
      hrdata_q <= (addr_ph && !hwrite) ? rd_mux : hrdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  // stopped after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= isc_pkg::CTRL_RST;
      high_q <= CNT_W'(isc_pkg::HIGH_RST);
      low_q <= CNT_W'(isc_pkg::LOW_RST);
      ien_q <= isc_pkg::IEN_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata[isc_pkg::CTRL_W-1:0];
      if (wr_high) high_q <= hwdata[CNT_W-1:0];
      if (wr_low) low_q <= hwdata[CNT_W-1:0];
      if (wr_ien) ien_q <= hwdata[isc_pkg::ST_W-1:0];
    end
  end

  wire run = ctrl_q[isc_pkg::CTRL_RUN];
  wire gen_on = run && ctrl_q[isc_pkg::CTRL_MST];

  ////////////////////////////////////////////////////////////////////////////
  // Input filters
  // filter enable separate from width
  isc_noise_filter #(.STAGES(isc_pkg::NF_STAGES)) u_nf_scl (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(scl_i),
    .en(ctrl_q[isc_pkg::CTRL_NFE]),
    .width(ctrl_q[isc_pkg::CTRL_NFW+1:isc_pkg::CTRL_NFW]),
    .dout(scl_f)
  );

  isc_noise_filter #(.STAGES(isc_pkg::NF_STAGES)) u_nf_sda (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(sda_i),
    .en(ctrl_q[isc_pkg::CTRL_NFE]),
    .width(ctrl_q[isc_pkg::CTRL_NFW+1:isc_pkg::CTRL_NFW]),
    .dout(sda_filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Line edges and match terms
  // line watched every cycle
  wire scl_rise = scl_f && !scl_f_q;
  wire scl_fall = !scl_f && scl_f_q;
  wire hi_match = (cnt_q == high_q);
  wire lo_match = (cnt_q == low_q);
  wire stretch = hold_tx || hold_nack || hold_rx;
  wire [CNT_W-1:0] cnt_inc = cnt_q + CNT_W'(1);

  // Clock generator next state; line levels, not our drive, time each bit
  // bit timing from line
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      isc_pkg::ISC_IDLE: begin
        cnt_d = '0;
        if (gen_on) st_d = isc_pkg::ISC_LOW;
      end
      isc_pkg::ISC_LOW: begin
        if (scl_fall) begin
          cnt_d = '0;
        end else if (lo_match && !stretch) begin
          cnt_d = '0;
          st_d = isc_pkg::ISC_REL;
        end else if (!lo_match && !scl_f) begin
          cnt_d = cnt_inc;
        end
      end
      isc_pkg::ISC_REL: begin
        if (scl_rise || scl_f) begin
          cnt_d = '0;
          st_d = isc_pkg::ISC_HIGH;
        end
      end
      isc_pkg::ISC_HIGH: begin
        if (scl_fall) begin
          cnt_d = '0;
          st_d = isc_pkg::ISC_LOW;
        end else if (hi_match) begin
          cnt_d = '0;
          st_d = isc_pkg::ISC_LOW;
        end else begin
          cnt_d = cnt_inc;
        end
      end
      default: begin
        st_d = isc_pkg::ISC_IDLE;
        cnt_d = '0;
      end
    endcase
    if (!gen_on) begin
      st_d = isc_pkg::ISC_IDLE;
      cnt_d = '0;
    end
  end

  // Generator registers
  // counters against settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= isc_pkg::ISC_IDLE;
      cnt_q <= '0;
      scl_f_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      scl_f_q <= scl_f;
    end
  end

  // Open-drain: drive low only in LOW, never drive high
  assign scl_o = 1'b0;
  assign scl_oe = (st_q == isc_pkg::ISC_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; set wins over write-one clear
  assign stat_d = (stat_q & ~(wr_iclr ? hwdata[isc_pkg::ST_W-1:0] : '0)) | (run ? evt : '0);
  assign req_evt = run ? {evt[isc_pkg::ST_TEND], evt[isc_pkg::ST_TXE], evt[isc_pkg::ST_RXF],
                          |(evt & isc_pkg::ST_ERR_MASK & ien_q)} : '0;

  // Pending flags: ack clears, event sets, stored request replays once cleared
  // store receive and transmit request while pending
  always_comb begin
    pend_d = req_evt | (pend_q & ~intc_ack) | (store_q & ~pend_q);
    store_d = (store_q & pend_q) | (req_evt & pend_q & ~intc_ack);
    store_d[isc_pkg::PND_ERR] = 1'b0;
    store_d[isc_pkg::PND_TEI] = 1'b0;
  end

  // Status and pending registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
      pend_q <= '0;
      store_q <= '0;
    end else begin
      stat_q <= stat_d;
      pend_q <= pend_d;
      store_q <= store_d;
    end
  end

  assign pend_flag = pend_q;
  assign irq = |(stat_q & ien_q);
  assign grp_flag = |(stat_q & ien_q & isc_pkg::ST_ERR_MASK);

  assign prio_valid = |pend_q;
  assign prio_src = pend_q[isc_pkg::PND_ERR] ? 2'h0 :
                    pend_q[isc_pkg::PND_RXI] ? 2'h1 :
                    pend_q[isc_pkg::PND_TXI] ? 2'h2 : 2'h3;

  // DMA from receive and transmit only
  assign dma_req = {pend_q[isc_pkg::PND_TXI] && ctrl_q[isc_pkg::CTRL_DTX],
                    pend_q[isc_pkg::PND_RXI] && ctrl_q[isc_pkg::CTRL_DRX]};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_high_match: assert property (
    gen_on && st_q == isc_pkg::ISC_HIGH && !scl_fall && hi_match && $stable(ctrl_q)
    |=> scl_oe && cnt_q == '0) else $error("high match did not drive low");

  a_low_release: assert property (
    gen_on && st_q == isc_pkg::ISC_LOW && lo_match && !stretch && !scl_fall && $stable(ctrl_q)
    |=> !scl_oe && st_q == isc_pkg::ISC_REL) else $error("low match did not release");

  a_rise_start: assert property (
    gen_on && st_q == isc_pkg::ISC_REL && !scl_f ##1 gen_on && scl_rise
    |=> st_q == isc_pkg::ISC_HIGH && cnt_q == '0) else $error("high count not started at rise");

  a_other_pull: assert property (
    gen_on && st_q == isc_pkg::ISC_HIGH && scl_fall && $stable(ctrl_q)
    |=> st_q == isc_pkg::ISC_LOW && cnt_q == '0) else $error("other master low ignored");

  a_stretch_hold: assert property (
    gen_on && st_q == isc_pkg::ISC_LOW && stretch && $stable(ctrl_q) |=> scl_oe)
    else $error("clock released during hold");

  a_stop_idle: assert property (
    !run |=> !scl_oe && st_q == isc_pkg::ISC_IDLE && cnt_q == '0) else $error("stopped module drives line");

  a_dma_source: assert property (
    dma_req != 2'b00 |-> (pend_q[isc_pkg::PND_RXI] || pend_q[isc_pkg::PND_TXI]))
    else $error("DMA from wrong source");

  a_store_replay: assert property (
    pend_q[isc_pkg::PND_RXI] && store_q[isc_pkg::PND_RXI] && intc_ack[isc_pkg::PND_RXI] && !req_evt[isc_pkg::PND_RXI]
    |=> !pend_q[isc_pkg::PND_RXI] ##1 pend_q[isc_pkg::PND_RXI]) else $error("stored request lost");

  a_ack_clear: assert property (
    pend_q[isc_pkg::PND_TEI] && intc_ack[isc_pkg::PND_TEI] && !req_evt[isc_pkg::PND_TEI]
    |=> !pend_q[isc_pkg::PND_TEI]) else $error("accept did not clear flag");

  a_grp_clear: assert property (
    (stat_q & isc_pkg::ST_ERR_MASK) == '0 |-> !grp_flag) else $error("group flag stuck");

endmodule
`default_nettype wire

// ===== test/isc_far_peer.sv
// Model of another master sharing the clock line
`timescale 1ns/10ps
`default_nettype none
module isc_far_peer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl_oe,
  input wire logic pull,
  input wire logic [7:0] stretch,
  output logic scl_i
);
  logic [7:0] hold_q; // Stretch cycles still to hold low

  ////////////////////////////////////////////////////////////////////////////
  // wired-AND line
  // Pull-up makes the line high unless some master drives it low
  assign scl_i = !(scl_oe || pull || hold_q != 8'h00);

  // Reload while the block drives low, so a slow peer keeps the line low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q <= 8'h00;
    end else if (scl_oe) begin
      hold_q <= stretch;
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/isc_top_tb.sv
// Self-checking bench for the clock generator and interrupt block
`timescale 1ns/10ps
`default_nettype none
module isc_top_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, prio_src, dma_req;
  logic [2:0] hsize;
  logic scl_i, scl_o, scl_oe, sda_i, sda_filt, hold_tx, hold_nack, hold_rx;
  logic [7:0] evt, stretch;
  logic [3:0] intc_ack, pend_flag;
  logic grp_flag, prio_valid, irq, pull, m;
  int fail_count = 0;
  int comparisons = 0;
  int lo1, hi1, lo2, hi2, lo3, hi3, n;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  isc_top dut (.*);
  isc_far_peer peer (.*);

  ////////////////////////////////////////////////////////////////////////////
  // Report and comparison helpers
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      fail_count++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite single word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    tmo(k, 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    tmo(k, 50);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock line timing and event helpers
  task automatic wait_lvl(input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge hclk);
      #1;
      cnt++;
    end while (scl_oe === lvl && cnt < 500);
    tmo(cnt, 500);
  endtask
  task automatic meas(output int lo, output int hi);
    int d;
    wait_lvl(1'b1, d);
    wait_lvl(1'b0, d);
    wait_lvl(1'b1, lo);
    wait_lvl(1'b0, hi);
  endtask
  task automatic glitch(input logic [31:0] ctrl, output logic mn);
    wr(isc_pkg::OFF_CTRL, ctrl);
    mn = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      sda_i <= (i < 2) ? 1'b0 : 1'b1;
      #1;
      mn = mn & sda_filt;
    end
  endtask
  task automatic pulse(input int b);
    @(posedge hclk);
    evt <= 8'h01 << b;
    @(posedge hclk);
    evt <= 8'h00;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic ack(input int b);
    @(posedge hclk);
    intc_ack <= 4'h1 << b;
    @(posedge hclk);
    intc_ack <= 4'h0;
    #1;
  endtask

  // Free-running bus clock, 4 ns period
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    {hold_tx, hold_nack, hold_rx, evt, intc_ack, pull, stretch} = '0;
    sda_i = 1'b1;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(scl_oe, 1'b0);
    // Open-drain output never drives high, bus always answers OKAY
    chk({hresp, scl_o}, 2'h0);
    // Live state: nothing pending, both lines idle high, generator idle
    rd_chk(isc_pkg::OFF_STATE, 32'hc);
    rd_chk(isc_pkg::OFF_CTRL, isc_pkg::CTRL_RST);
    rd_chk(isc_pkg::OFF_HIGH, isc_pkg::HIGH_RST);
    rd_chk(isc_pkg::OFF_LOW, isc_pkg::LOW_RST);
    rd_chk(isc_pkg::OFF_IEN, isc_pkg::IEN_RST);
    rd_chk(8'h1c, 32'h0);
    pulse(isc_pkg::ST_RXF);
    rd_chk(isc_pkg::OFF_STAT, 32'h0);
    chk(scl_oe, 1'b0);
    // Rate and duty from the two period settings
    wr(isc_pkg::OFF_CTRL, 32'h23);
    wr(isc_pkg::OFF_HIGH, 32'h4);
    wr(isc_pkg::OFF_LOW, 32'h6);
    meas(lo1, hi1);
    wr(isc_pkg::OFF_HIGH, 32'h8);
    wr(isc_pkg::OFF_LOW, 32'h9);
    meas(lo2, hi2);
    chk_n(lo2 - lo1, 3);
    chk_n(hi2 - hi1, 4);
    // Slow peer delays the rising edge
    @(posedge hclk);
    stretch <= 8'h05;
    meas(lo3, hi3);
    chk_n(hi3 - hi2, 5);
    chk_n(lo3, lo2);
    @(posedge hclk);
    stretch <= 8'h00;
    // Other master cuts the high period short
    meas(lo3, hi3);
    wait_lvl(1'b1, n);
    repeat (2) @(posedge hclk);
    pull <= 1'b1;
    wait_lvl(1'b0, n);
    chk_n(int'(n + 3 < hi2), 1);
    @(posedge hclk);
    pull <= 1'b0;
    // Low count already runs from the other master's edge, so this low is short
    wait_lvl(1'b1, n);
    chk_n(n + 3, lo2);
    // Each hold request keeps the line low
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk);
      {hold_rx, hold_nack, hold_tx} <= 3'h1 << i;
      wait_lvl(1'b0, n);
      repeat (40) @(posedge hclk);
      #1;
      chk(scl_oe, 1'b1);
      @(posedge hclk);
      {hold_rx, hold_nack, hold_tx} <= 3'h0;
      wait_lvl(1'b1, n);
    end
    // Filter enable apart from width select
    glitch(32'h3f, m);
    chk(m, 1'b1);
    glitch(32'h3b, m);
    chk(m, 1'b0);
    // Filter on with a two-sample window lets the same glitch through
    glitch(32'h2f, m);
    chk(m, 1'b0);
    wr(isc_pkg::OFF_CTRL, 32'h23);
    // Receive full, stored request, accept and priority
    pulse(isc_pkg::ST_RXF);
    chk(pend_flag, 4'h2);
    chk(dma_req, 2'h1);
    chk(irq, 1'b0);
    pulse(isc_pkg::ST_TEND);
    chk(dma_req, 2'h1);
    chk({prio_valid, prio_src}, 3'h5);
    pulse(isc_pkg::ST_RXF);
    ack(isc_pkg::PND_RXI);
    chk(pend_flag[1], 1'b0);
    repeat (3) @(posedge hclk);
    #1;
    chk(pend_flag[1], 1'b1);
    ack(isc_pkg::PND_RXI);
    repeat (3) @(posedge hclk);
    #1;
    chk(pend_flag, 4'h8);
    // Error group with its enable and clear
    wr(isc_pkg::OFF_IEN, 32'h1);
    pulse(isc_pkg::ST_AL);
    chk({grp_flag, irq, prio_src}, 4'hc);
    rd_chk(isc_pkg::OFF_STAT, 32'ha1);
    ack(isc_pkg::PND_ERR);
    chk(pend_flag[0], 1'b0);
    wr(isc_pkg::OFF_ICLR, 32'h1);
    #1;
    chk({grp_flag, irq}, 2'h0);
    rd_chk(isc_pkg::OFF_STAT, 32'ha0);
    // Transmit empty DMA and interrupt masking
    wr(isc_pkg::OFF_CTRL, 32'h63);
    pulse(isc_pkg::ST_TXE);
    chk(dma_req, 2'h2);
    // Transmit empty outranks transmit end; accepts clear each in turn
    chk({prio_valid, prio_src}, 3'h6);
    ack(isc_pkg::PND_TXI);
    chk({prio_valid, prio_src}, 3'h7);
    ack(isc_pkg::PND_TEI);
    chk(pend_flag, 4'h0);
    chk(irq, 1'b0);
    wr(isc_pkg::OFF_IEN, 32'h40);
    #1;
    chk(irq, 1'b1);
    wr(isc_pkg::OFF_ICLR, 32'hff);
    #1;
    chk(irq, 1'b0);
    rd_chk(isc_pkg::OFF_STAT, 32'h0);
    rd_chk(isc_pkg::OFF_ICLR, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
